// file: verilog/position_pkg.sv
// Constants and register map for the position management block
// What this block does
// - Method codes 33 and 34 start a move from present position to index.
// - Index is one pulse per revolution, same angle, about 1/16 wide.
// - Index homing searches one revolution and stops on the index edge.
// - Method 35 loads present position with the setting value, new zero.
// - Position setting is accepted only at motor standstill.
// - Position setting keeps the outstanding position deviation.
// - Signed 32-bit setting value, default zero, at address 6956.
// - Reference position readable, signed 32-bit, read only, address 7704.
// - Default range runs from -1073741824 to 1073741823 user units.
// - Travel beyond range allowed except absolute profile positioning.
// - Travelling past a range limit invalidates the reference point.
// - Relative move over range zeroes position at start, clears ref flag.
// - Soft limits act only with valid reference, relative to zero point.
// - Enable field at 1542: 0 none, 1 positive, 2 negative, 3 both.
// - Soft limit positions default to extremes; out of range is clamped.
// - Bit 2 of latched status is set when a soft limit triggers.
// - Present motor position is readable in user units.
package position_pkg;
	localparam logic [15:0] ADDR_SOFT_LIMIT_ENABLE = 16'h0606;
	localparam logic [15:0] ADDR_SOFT_LIMIT_POS    = 16'h0608;
	localparam logic [15:0] ADDR_SOFT_LIMIT_NEG    = 16'h060a;
	localparam logic [15:0] ADDR_HOMING_SET_POS    = 16'h1b2c;
	localparam logic [15:0] ADDR_REF_POS_READBACK  = 16'h1e18;

	localparam logic [15:0] RESET_SOFT_LIMIT_ENABLE = 16'h0000;
	localparam logic [31:0] RESET_SOFT_LIMIT_POS    = 32'h7fffffff;
	localparam logic [31:0] RESET_SOFT_LIMIT_NEG    = 32'h80000000;
	localparam logic [31:0] RESET_HOMING_SET_POS    = 32'h00000000;
	localparam logic [31:0] RESET_REF_POS           = 32'h00000000;

	localparam logic [31:0] RANGE_LOW  = 32'hc0000000;
	localparam logic [31:0] RANGE_HIGH = 32'h3fffffff;
	localparam logic [31:0] USER_MAX   = 32'h7fffffff;
	localparam logic [31:0] USER_MIN   = 32'h80000000;

	localparam logic [7:0] METHOD_INDEX_NEG = 8'h21;
	localparam logic [7:0] METHOD_INDEX_POS = 8'h22;
	localparam logic [7:0] METHOD_POS_SET   = 8'h23;

	localparam int STATUS_SOFT_LIMIT_BIT = 2;
	localparam int ENABLE_POS_BIT        = 0;
	localparam int ENABLE_NEG_BIT        = 1;

	localparam int STEPS_PER_REV_DEFAULT = 12800;

	typedef enum logic [1:0] {
		HOME_IDLE   = 2'b00,
		HOME_SEARCH = 2'b01,
		HOME_FOUND  = 2'b11,
		HOME_FAIL   = 2'b10
	} home_state_t;
endpackage

// file: verilog/homing_position_range_soft_limits.sv
// Homing, positioning range and software limit logic of the drive
`timescale 1ns/100ps
module homing_position_range_soft_limits
#(
	parameter int STEPS_PER_REV = position_pkg::STEPS_PER_REV_DEFAULT
)
(
	input  wire logic        core_clk,
	input  wire logic        rst_n,
	input  wire logic [15:0] regAddr,
	input  wire logic        regWrite,
	input  wire logic        regRead,
	input  wire logic [31:0] regWdata,
	output logic      [31:0] regRdata,
	output logic             regAck,
	output logic             regErr,
	input  wire logic [7:0]  homingMethodSelect,
	input  wire logic        homingStart,
	input  wire logic        motorStandstill,
	input  wire logic        indexPin,
	input  wire logic        motorStep,
	input  wire logic        motorStepDir,
	input  wire logic        demandStep,
	input  wire logic        demandStepDir,
	input  wire logic        moveStart,
	input  wire logic        moveRelative,
	input  wire logic [31:0] moveValue,
	input  wire logic        absoluteProfileMode,
	input  wire logic        latchedStatusClear,
	output logic      [31:0] actualPosition,
	output logic      [31:0] demandPosition,
	output logic      [31:0] moveTarget,
	output logic             moveAccepted,
	output logic             moveRefused,
	output logic             homingMoveReq,
	output logic             homingMoveDir,
	output logic             homingDone,
	output logic             homingFailed,
	output logic             homingRefused,
	output logic             referenceValid,
	output logic      [15:0] latchedSignalStatus,
	output logic             allowPositive,
	output logic             allowNegative
);
	import position_pkg::*;

	// Signed range check, used by overtravel and move checks
	function automatic logic inRange(input logic [31:0] p);
		inRange = ($signed(p) >= $signed(RANGE_LOW)) &&
			($signed(p) <= $signed(RANGE_HIGH));
	endfunction

	logic [15:0] softLimitEnableSelect;
	logic [31:0] positiveSoftLimit;
	logic [31:0] negativeSoftLimit;
	logic [31:0] positionSettingValue;
	logic [31:0] referencePosition;
	logic        indexSync1;
	logic        indexSync2;
	logic        indexPrev;
	logic        indexEdge;
	home_state_t homeState;
	logic [31:0] searchCount;
	logic        positionSetNow;
	logic        indexRefNow;
	logic        relativeZeroNow;
	logic [31:0] deviation;
	logic [31:0] loadValue;
	logic        loadNow;
	logic [31:0] relTarget;
	logic        positiveLimitOn;
	logic        negativeLimitOn;
	logic        positiveDirectionLimitOn;
	logic        negativeDirectionLimitOn;
	logic        softLimitHit;
	logic        atRangeHigh;
	logic        atRangeLow;
	logic        actStepPos;
	logic        actStepNeg;
	logic [31:0] next_actual;

	// Index pin comes from the shaft sensor, so two flops first
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			indexSync1 <= 1'b0;
			indexSync2 <= 1'b0;
			indexPrev  <= 1'b0;
		end
		else
		begin
			indexSync1 <= indexPin;
			indexSync2 <= indexSync1;
			indexPrev  <= indexSync2;
		end
	end

	// The pulse covers a sixteenth of a turn; rising going up and falling
	// going down are one and the same angle, so homing stays repeatable
	assign indexEdge = homingMoveDir ? (indexSync2 && !indexPrev)
		: (!indexSync2 && indexPrev);

	// Register writes; clamping keeps an entry outside the positioning range
	// from wrapping into a bogus limit
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			softLimitEnableSelect <= RESET_SOFT_LIMIT_ENABLE;
			positiveSoftLimit     <= RESET_SOFT_LIMIT_POS;
			negativeSoftLimit     <= RESET_SOFT_LIMIT_NEG;
			positionSettingValue  <= RESET_HOMING_SET_POS;
		end
		else if (regWrite)
		begin
			unique case (regAddr)
				ADDR_SOFT_LIMIT_ENABLE:
					softLimitEnableSelect <= {14'h0000, regWdata[1:0]};
				ADDR_SOFT_LIMIT_POS:
					positiveSoftLimit <= ($signed(regWdata) > $signed(RANGE_HIGH))
						? USER_MAX : regWdata;
				ADDR_SOFT_LIMIT_NEG:
					negativeSoftLimit <= ($signed(regWdata) < $signed(RANGE_LOW))
						? USER_MIN : regWdata;
				ADDR_HOMING_SET_POS:
					positionSettingValue <= regWdata;
				default:
					positionSettingValue <= positionSettingValue;
			endcase
		end
	end

	// Register answers, one cycle after the strobe
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			regRdata <= 32'h00000000;
			regAck   <= 1'b0;
			regErr   <= 1'b0;
		end
		else
		begin
			regAck <= 1'b0;
			regErr <= 1'b0;
			if (regRead)
			begin
				regAck <= 1'b1;
				unique case (regAddr)
					ADDR_SOFT_LIMIT_ENABLE:
						regRdata <= {16'h0000, softLimitEnableSelect};
					ADDR_SOFT_LIMIT_POS:
						regRdata <= positiveSoftLimit;
					ADDR_SOFT_LIMIT_NEG:
						regRdata <= negativeSoftLimit;
					ADDR_HOMING_SET_POS:
						regRdata <= positionSettingValue;
					ADDR_REF_POS_READBACK:
						regRdata <= referencePosition;
					default:
					begin
						regRdata <= 32'h00000000;
						regErr   <= 1'b1;
					end
				endcase
			end
			else if (regWrite)
			begin
				regAck <= 1'b1;
				// Read-only readback and unmapped addresses are refused
				regErr <= !((regAddr == ADDR_SOFT_LIMIT_ENABLE) ||
					(regAddr == ADDR_SOFT_LIMIT_POS) ||
					(regAddr == ADDR_SOFT_LIMIT_NEG) ||
					(regAddr == ADDR_HOMING_SET_POS));
			end
		end
	end

	// Homing requests: position setting needs standstill and an idle sequencer, else it is refused
	assign positionSetNow = homingStart && (homeState == HOME_IDLE) &&
		(homingMethodSelect == METHOD_POS_SET) && motorStandstill;
	assign indexRefNow = (homeState == HOME_SEARCH) && indexEdge;

	// Relative profile move: target is checked before the move starts
	assign relTarget = actualPosition + moveValue;
	assign relativeZeroNow = moveStart && moveRelative &&
		!inRange(relTarget);

	// Any position load keeps the demand-to-actual gap, so the position
	// loop still closes the deviation afterwards
	assign deviation = demandPosition - actualPosition;
	assign loadNow   = positionSetNow || indexRefNow || relativeZeroNow;
	assign loadValue = positionSetNow ? positionSettingValue : 32'h00000000;

	// Soft limit evaluation relative to the zero point
	assign positiveDirectionLimitOn = softLimitEnableSelect[ENABLE_POS_BIT];
	assign negativeDirectionLimitOn = softLimitEnableSelect[ENABLE_NEG_BIT];
	assign positiveLimitOn = referenceValid && positiveDirectionLimitOn &&
		($signed(actualPosition) >= $signed(positiveSoftLimit));
	assign negativeLimitOn = referenceValid && negativeDirectionLimitOn &&
		($signed(actualPosition) <= $signed(negativeSoftLimit));
	assign softLimitHit = positiveLimitOn || negativeLimitOn;

	// Range edges only stop motion in absolute profile positioning
	assign atRangeHigh = absoluteProfileMode &&
		($signed(actualPosition) >= $signed(RANGE_HIGH));
	assign atRangeLow = absoluteProfileMode &&
		($signed(actualPosition) <= $signed(RANGE_LOW));

	// Halting one direction leaves the way back open
	assign allowPositive = !positiveLimitOn && !atRangeHigh;
	assign allowNegative = !negativeLimitOn && !atRangeLow;

	assign actStepPos = motorStep && motorStepDir;
	assign actStepNeg = motorStep && !motorStepDir;

	// Next actual position from motor steps
	always_comb
	begin
		next_actual = actualPosition;
		if (actStepPos)
			next_actual = actualPosition + 32'h00000001;
		else if (actStepNeg)
			next_actual = actualPosition - 32'h00000001;
	end

	// Actual and demand positions; a load wins over a step that cycle
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			actualPosition <= 32'h00000000;
			demandPosition <= 32'h00000000;
		end
		else if (loadNow)
		begin
			actualPosition <= loadValue;
			demandPosition <= loadValue + deviation;
		end
		else
		begin
			actualPosition <= next_actual;
			if (demandStep && demandStepDir)
				demandPosition <= demandPosition + 32'h00000001;
			else if (demandStep)
				demandPosition <= demandPosition - 32'h00000001;
		end
	end

	// Reference flag and readback value
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			referenceValid    <= 1'b0;
			referencePosition <= RESET_REF_POS;
		end
		else if (relativeZeroNow)
			referenceValid <= 1'b0;
		else if (positionSetNow || indexRefNow)
		begin
			referenceValid    <= 1'b1;
			referencePosition <= loadValue;
		end
		else if (motorStep && inRange(actualPosition) &&
			!inRange(next_actual))
			referenceValid <= 1'b0;
	end

	// Profile move answer; absolute targets must stay inside the range
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			moveTarget   <= 32'h00000000;
			moveAccepted <= 1'b0;
			moveRefused  <= 1'b0;
		end
		else
		begin
			moveAccepted <= 1'b0;
			moveRefused  <= 1'b0;
			if (moveStart && moveRelative)
			begin
				moveAccepted <= 1'b1;
				moveTarget   <= relativeZeroNow ? moveValue : relTarget;
			end
			else if (moveStart && inRange(moveValue))
			begin
				moveAccepted <= 1'b1;
				moveTarget   <= moveValue;
			end
			else if (moveStart)
				moveRefused <= 1'b1;
		end
	end

	// Index search sequencer; gives up after one full revolution
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			homeState     <= HOME_IDLE;
			searchCount   <= 32'h00000000;
			homingMoveDir <= 1'b0;
		end
		else
		begin
			unique case (homeState)
				HOME_IDLE:
					if (homingStart && ((homingMethodSelect == METHOD_INDEX_NEG) ||
						(homingMethodSelect == METHOD_INDEX_POS)))
					begin
						homeState     <= HOME_SEARCH;
						homingMoveDir <= (homingMethodSelect == METHOD_INDEX_POS);
						searchCount   <= 32'h00000000;
					end
				HOME_SEARCH:
					if (indexEdge)
						homeState <= HOME_FOUND;
					else if (searchCount >= 32'(STEPS_PER_REV))
						homeState <= HOME_FAIL;
					else if (motorStep)
						searchCount <= searchCount + 32'h00000001;
				HOME_FOUND:
					homeState <= HOME_IDLE;
				HOME_FAIL:
					homeState <= HOME_IDLE;
			endcase
		end
	end

	// Motion request stops the very cycle the edge is seen
	assign homingMoveReq = (homeState == HOME_SEARCH) && !indexEdge;
	assign homingDone    = (homeState == HOME_FOUND);
	assign homingFailed  = (homeState == HOME_FAIL);

	// Refusal pulse for position setting while moving or when busy
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
			homingRefused <= 1'b0;
		else
			homingRefused <= homingStart && (homingMethodSelect == METHOD_POS_SET)
				&& !positionSetNow;
	end

	// Latched status: a new trigger beats a clear in the same cycle
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
			latchedSignalStatus <= 16'h0000;
		else if (softLimitHit)
			latchedSignalStatus[STATUS_SOFT_LIMIT_BIT] <= 1'b1;
		else if (latchedStatusClear)
			latchedSignalStatus[STATUS_SOFT_LIMIT_BIT] <= 1'b0;
	end
endmodule

// file: bench/homing_position_range_soft_limits_props.sv
// Port-level assertions for the position management block
`timescale 1ns/100ps
module homing_position_range_soft_limits_props
(
	input wire logic        core_clk,
	input wire logic        rst_n,
	input wire logic [15:0] regAddr,
	input wire logic        regWrite,
	input wire logic        regRead,
	input wire logic        regAck,
	input wire logic        regErr,
	input wire logic [7:0]  homingMethodSelect,
	input wire logic        homingStart,
	input wire logic        motorStandstill,
	input wire logic        moveStart,
	input wire logic        moveRelative,
	input wire logic [31:0] moveValue,
	input wire logic        absoluteProfileMode,
	input wire logic [31:0] actualPosition,
	input wire logic        moveRefused,
	input wire logic        homingMoveReq,
	input wire logic        homingDone,
	input wire logic        homingRefused,
	input wire logic        referenceValid,
	input wire logic [15:0] latchedSignalStatus,
	input wire logic        allowPositive,
	input wire logic        allowNegative
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	// A start taken while no homing is in progress
	sequence s_start(m);
		homingStart && !homingMoveReq && !homingDone
			&& homingMethodSelect == m;
	endsequence
	a_reg_ack: assert property ((regRead || regWrite) |=> regAck)
		else $error("register strobe got no acknowledge");
	a_ro_write: assert property (regWrite && !regRead
		&& regAddr == 16'h1e18 |=> regErr)
		else $error("write to read-only place not refused");
	a_set_loads: assert property (s_start(8'h23) ##0 motorStandstill
		|-> ##[1:2] referenceValid)
		else $error("position setting gave no reference");
	a_set_moving: assert property (s_start(8'h23) ##0 !motorStandstill
		|=> homingRefused)
		else $error("position setting while moving not refused");
	a_index_search: assert property ((s_start(8'h21)
		or s_start(8'h22)) |=> homingMoveReq)
		else $error("index homing did not request motion");
	a_done_zero: assert property (homingDone
		|-> actualPosition == 32'h0 && referenceValid)
		else $error("index homing did not stop at zero");
	a_abs_refuse: assert property (moveStart && !moveRelative
		&& $signed(moveValue) > 32'sh3fffffff |=> moveRefused)
		else $error("absolute move beyond range accepted");
	a_limit_ref: assert property (!referenceValid && !absoluteProfileMode
		|-> allowPositive && allowNegative)
		else $error("soft limit acted without reference");
	a_limit_latch: assert property (!absoluteProfileMode
		&& !(allowPositive && allowNegative) |=> latchedSignalStatus[2])
		else $error("soft limit hit not latched");
endmodule

// file: bench/shaft_index_model.sv
// Motor shaft model: step source and one-per-turn index sensor
`timescale 1ns/100ps
module shaft_index_model
#(
	parameter int STEPS       = 16,
	parameter int INDEX_ANGLE = 9
)
(
	input  wire logic core_clk,
	input  wire logic rst_n,
	input  wire logic homingMoveReq,
	input  wire logic homingMoveDir,
	input  wire logic benchStep,
	input  wire logic benchDir,
	input  wire logic indexMask,
	output logic      motorStep,
	output logic      motorStepDir,
	output logic      indexPin
);
	int   angle;
	logic slow;
	// Homing steps every other cycle, so the slow case is always exercised
	always_ff @(posedge core_clk)
	begin
		slow <= rst_n && !slow && homingMoveReq;
		motorStep <= rst_n && (benchStep || (homingMoveReq && !slow));
		motorStepDir <= homingMoveReq ? homingMoveDir : benchDir;
		if (!rst_n)
			angle <= 0;
		else if (motorStep)
			angle <= (angle + (motorStepDir ? 1 : STEPS - 1)) % STEPS;
	end
	// One step of STEPS wide at a fixed angle: 1/16 turn for 16 steps;
	// the mask stands for a dead sensor so a search can run out
	assign indexPin = (angle == INDEX_ANGLE) && !indexMask;
endmodule

// file: bench/homing_position_range_soft_limits_bench.sv
// Self-checking bench for the position management block
`timescale 1ns/100ps
module homing_position_range_soft_limits_bench;
	import position_pkg::*;
	typedef struct {logic w; logic [15:0] a; logic [31:0] d, q; logic e;} row_t;
	logic        core_clk = 0, rst_n = 0, regWrite = 0, regRead = 0;
	logic        homingStart = 0, motorStandstill = 1, demandStep = 0;
	logic        demandStepDir = 1, moveStart = 0, moveRelative = 0;
	logic        absoluteProfileMode = 0, latchedStatusClear = 0;
	logic        indexMask = 0;
	logic        benchStep = 0, benchDir = 1, regAck, regErr, moveAccepted;
	logic        moveRefused, homingMoveReq, homingMoveDir, homingDone;
	logic        homingFailed, homingRefused, referenceValid, indexPin;
	logic        allowPositive, allowNegative, motorStep, motorStepDir;
	logic [15:0] regAddr = 0, latchedSignalStatus;
	logic [7:0]  homingMethodSelect = 0;
	logic [31:0] regWdata = 0, moveValue = 0, regRdata, actualPosition;
	logic [31:0] demandPosition, moveTarget;
	logic [31:0] lim[2] = '{32'h00001234, 32'hffffff38};
	int          miscompares = 0, n_tests = 0, cyc = 0;
	row_t        rows[12] = '{
		'{1'h0, 16'h0606, 32'h0, 32'h0, 1'h0},
		'{1'h0, 16'h0608, 32'h0, 32'h7fffffff, 1'h0},
		'{1'h0, 16'h060a, 32'h0, 32'h80000000, 1'h0},
		'{1'h0, 16'h1e18, 32'h0, 32'h0, 1'h0},
		'{1'h1, 16'h0608, 32'h50000000, 32'h7fffffff, 1'h0},
		'{1'h1, 16'h060a, 32'hb0000000, 32'h80000000, 1'h0},
		'{1'h1, 16'h0608, 32'h64, 32'h64, 1'h0},
		'{1'h1, 16'h060a, 32'hffffff9c, 32'hffffff9c, 1'h0},
		'{1'h1, 16'h0606, 32'h3, 32'h3, 1'h0},
		'{1'h1, 16'h1b2c, 32'h1234, 32'h1234, 1'h0},
		'{1'h1, 16'h1e18, 32'h5, 32'h0, 1'h1},
		'{1'h0, 16'h0700, 32'h0, 32'h0, 1'h1}};
	homing_position_range_soft_limits #(.STEPS_PER_REV(16))
		homing_position_range_soft_limits_i (.*);
	shaft_index_model shaft_index_model_i (.*);
	// Clock and a cycle ceiling far above the expected run
	always #50 core_clk = !core_clk;
	always @(posedge core_clk)
	begin
		cyc++;
		if (cyc == 5000)
		begin
			miscompares++;
			conclude();
		end
	end
	task automatic chk(string n, logic [31:0] e, logic [31:0] s);
		n_tests++;
		if (s !== e)
		begin
			miscompares++;
			$display("Error %s expected %h seen %h", n, e, s);
		end
	endtask
	// One strobe, answer looked at in the cycle after it is taken
	task automatic acc(logic w, logic [15:0] a, logic [31:0] d);
		@(negedge core_clk);
		regWrite = w;
		regRead = !w;
		regAddr = a;
		regWdata = d;
		@(negedge core_clk);
		regWrite = 0;
		regRead = 0;
		chk("regAck", 1, regAck);
	endtask
	task automatic pulse(ref logic s);
		@(negedge core_clk);
		s = 1;
		@(negedge core_clk);
		s = 0;
	endtask
	task automatic setp(logic [31:0] v);
		acc(1'h1, 16'h1b2c, v);
		homingMethodSelect = METHOD_POS_SET;
		pulse(homingStart);
		@(negedge core_clk);
		chk("setPosition", v, actualPosition);
	endtask
	task automatic conclude();
		$display("Comparisons %0d, mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	initial
	begin
		repeat (5) @(negedge core_clk);
		rst_n = 1;
		foreach (rows[i])
		begin
			if (rows[i].w)
				acc(1'h1, rows[i].a, rows[i].d);
			if (rows[i].w)
				chk("writeErr", rows[i].e, regErr);
			acc(1'h0, rows[i].a, 32'h0);
			chk("readData", rows[i].q, regRdata);
			chk("readErr", !rows[i].w && rows[i].e, regErr);
		end
		motorStandstill = 0;
		homingMethodSelect = METHOD_POS_SET;
		pulse(homingStart);
		chk("refused", 1, homingRefused);
		motorStandstill = 1;
		// Two demand steps up and one down leave a deviation of one
		pulse(demandStep);
		pulse(demandStep);
		demandStepDir = 0;
		pulse(demandStep);
		demandStepDir = 1;
		setp(32'h1234);
		chk("demand", 32'h1235, demandPosition);
		acc(1'h0, 16'h1e18, 32'h0);
		chk("refPos", 32'h1234, regRdata);
		// Above the positive limit, then below the negative one
		foreach (lim[p])
		begin
			setp(lim[p]);
			for (int c = 0; c < 4; c++)
			begin
				acc(1'h1, 16'h0606, 32'(c));
				chk("allowPos", !(p == 0 && c[0]), allowPositive);
				chk("allowNeg", !(p == 1 && c[1]), allowNegative);
			end
		end
		chk("latched", 1, latchedSignalStatus[2]);
		acc(1'h1, 16'h0606, 32'h0);
		pulse(latchedStatusClear);
		@(negedge core_clk);
		chk("cleared", 0, latchedSignalStatus[2]);
		// Step past the upper range limit
		setp(32'h3fffffff);
		pulse(benchStep);
		repeat (3) @(negedge core_clk);
		chk("overtravel", 0, referenceValid);
		chk("beyond", 32'h40000000, actualPosition);
		setp(32'h3fffffff);
		// Relative move inside the range keeps the reference; one beyond it zeroes position and reference
		moveRelative = 1;
		moveValue = 32'hfffffff6;
		pulse(moveStart);
		chk("relTarget", 32'h3ffffff5, moveTarget);
		chk("relKeep", 1, referenceValid);
		moveValue = 32'ha;
		pulse(moveStart);
		chk("accepted", 1, moveAccepted);
		@(negedge core_clk);
		chk("relZero", 0, actualPosition);
		chk("relRef", 0, referenceValid);
		chk("target", 32'ha, moveTarget);
		moveRelative = 0;
		absoluteProfileMode = 1;
		moveValue = 32'h40000000;
		pulse(moveStart);
		chk("absRefused", 1, moveRefused);
		moveValue = 32'h3fffffff;
		pulse(moveStart);
		chk("absAccepted", 1, moveAccepted);
		chk("absTarget", 32'h3fffffff, moveTarget);
		setp(32'h3fffffff);
		chk("absStop", 0, allowPositive);
		absoluteProfileMode = 0;
		// Index homing in both directions
		for (int m = 33; m < 35; m++)
		begin
			homingMethodSelect = 8'(m);
			pulse(homingStart);
			chk("searchReq", 1, homingMoveReq);
			chk("searchDir", m == 34, homingMoveDir);
			for (int k = 0; k < 200 && homingDone !== 1'b1; k++)
				@(negedge core_clk);
			chk("done", 1, homingDone);
			chk("indexZero", 0, actualPosition);
			chk("indexRef", 1, referenceValid);
			@(negedge core_clk);
		end
		// Dead sensor: a busy search refuses setting, then gives up
		indexMask = 1;
		homingMethodSelect = METHOD_INDEX_POS;
		pulse(homingStart);
		homingMethodSelect = METHOD_POS_SET;
		pulse(homingStart);
		chk("busyRefused", 1, homingRefused);
		for (int k = 0; k < 200 && homingFailed !== 1'b1; k++)
			@(negedge core_clk);
		chk("failed", 1, homingFailed);
		chk("failReq", 0, homingMoveReq);
		indexMask = 0;
		// Reset in mid-run brings registers and flags back to defaults
		acc(1'h1, 16'h0606, 32'h3);
		rst_n = 0;
		repeat (2) @(negedge core_clk);
		rst_n = 1;
		chk("rstRef", 0, referenceValid);
		chk("rstActual", 0, actualPosition);
		acc(1'h0, 16'h0606, 32'h0);
		chk("rstEnable", 0, regRdata);
		acc(1'h0, 16'h1b2c, 32'h0);
		chk("rstSetting", 0, regRdata);
		conclude();
	end
endmodule
bind homing_position_range_soft_limits homing_position_range_soft_limits_props
	homing_position_range_soft_limits_props_i (.*);
